// ---- rtl/dbg_watch_cfg.svh ----
/*
 * constants of the core debug watch unit: register selects, field
 * positions, write masks, vectors, version, boot settle count.
 * assumes inclusion by bare name from rtl files.
 */
`ifndef DBG_WATCH_CFG_SVH
`define DBG_WATCH_CFG_SVH

`define SEL_INSTR_WATCH_ADDR 3'h0
`define SEL_INSTR_WATCH_CTRL 3'h1
`define SEL_DATA_WATCH_ADDR 3'h2
`define SEL_DATA_WATCH_CTRL 3'h3
`define SEL_DEBUG_STATUS 3'h4
`define SEL_EXT_DEBUG 3'h5
`define SEL_RETURN_PC 3'h6
`define SEL_SCRATCH 3'h7

`define MORE_PAIRS_BIT 31
`define WATCH_CTRL_RW_MASK 32'h40ff_0ff8
`define IW_ADDR_MASK 64'hffff_ffff_ffff_fffc
`define DW_ADDR_MASK 64'hffff_ffff_ffff_fffb
`define DW_LOAD_BIT 1
`define DW_STORE_BIT 0
`define IW_ENABLE_BIT 2
`define WATCH_VADDR_LO 3

`define DBG_MODE_BIT 30
`define DBG_NO_CTRL_REG_BIT 29
`define DBG_NORMAL_MEM_BIT 28
`define DBG_MCHK_BIT 23
`define DBG_CERR_BIT 22
`define DBG_BERR_BIT 21
`define DBG_IEXI_BIT 20
`define DBG_IMPR_HI 19
`define DBG_IMPR_LO 18
`define DBG_VER_HI 17
`define DBG_VER_LO 15
`define DBG_VERSION 3'h1
`define DBG_SSTEP_BIT 8
`define DBG_INT_STATUS_BIT 5
`define DBG_IW_BIT 4
`define DBG_SW_BIT 3
`define DBG_LW_BIT 2
`define DBG_BP_BIT 1
`define DBG_SS_BIT 0

`define EXT_EN_BIT 31
`define EXT_ALT_BIT 30
`define EXT_PRV_BIT 8
`define EXT_EVENT_BIT 5
`define EXT_TRIG_HI 4
`define EXT_TRIG_LO 2

`define RESET_VECTOR 64'hffff_ffff_bfc0_0000
`define ALT_DEBUG_VECTOR 64'hffff_ffff_b000_0480
`define STD_DEBUG_VECTOR 64'hffff_ffff_bfc0_0480
// edges after reset release before the boot strap has crossed the
// agent flop and both sync stages
`define BOOT_SETTLE_CNT 2'h3

`endif

// ---- rtl/dbg_watch_pkg.sv ----
/*
 * types shared by the debug watch unit and the bench; the agent does not use them.
 * assumes nothing beyond the cfg header for constants.
 */
`default_nettype none
package dbg_watch_pkg;
    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_SUPER = 2'b01,
        MODE_KERNEL = 2'b10,
        MODE_EXC = 2'b11
    } cpu_mode_e;
    typedef logic [63:0] word_t;
endpackage
`default_nettype wire

// ---- rtl/dbg_pins_if.sv ----
/*
 * pins between the debug unit and the external debug agent.
 * assumes both ends run on one sys_clk.
 */
`default_nettype none
interface dbg_pins_if;
    logic debug_interrupt_pin;
    logic debug_boot_pin;
    logic debug_event_notify_pin;
    modport unit
    (
        input debug_interrupt_pin,
        input debug_boot_pin,
        output debug_event_notify_pin
    );
    modport agent
    (
        output debug_interrupt_pin,
        output debug_boot_pin,
        input debug_event_notify_pin
    );
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
/*
 * two flip-flop synchroniser for one level input.
 * assumes async input, sys_clk domain output.
 */
`default_nettype none
module pin_sync
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;
    sync_s st_ff;
    sync_s nxt_st;

    always_comb
    begin
        nxt_st.s1 = pin;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign level = st_ff.s2;
endmodule
`default_nettype wire

// ---- rtl/debug_agent.sv ----
/*
 * external debug agent end: drives interrupt and boot pins from user
 * requests, reports the event pin back.
 * assumes the unit samples the pins through synchronisers.
 */
`default_nettype none
`include "dbg_watch_cfg.svh"
module debug_agent
(
    input wire logic sys_clk,
    input wire logic arst_n,
    dbg_pins_if.agent pins,
    input wire logic want_interrupt,
    input wire logic want_boot,
    output logic event_seen
);
    typedef struct packed {
        logic intr;
        logic boot;
        logic evt_s1;
        logic evt_s2;
    } agent_s;
    agent_s st_ff;
    agent_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.intr = want_interrupt;
        nxt_st.boot = want_boot;
        nxt_st.evt_s1 = pins.debug_event_notify_pin;
        nxt_st.evt_s2 = st_ff.evt_s1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pins.debug_interrupt_pin = st_ff.intr;
    assign pins.debug_boot_pin = st_ff.boot;
    assign event_seen = st_ff.evt_s2;
endmodule
`default_nettype wire

// ---- rtl/core_debug_watch_unit.sv ----
/*
 * core debug watch unit: two watch pairs, debug status, return pc,
 * scratch and extended debug control; decides debug entry and vector.
 * assumes the core gives one-cycle strobes for register writes,
 * retire, breakpoint instruction and debug return, and holds reg_sel
 * stable while reading.
 */
`default_nettype none
`include "dbg_watch_cfg.svh"
module core_debug_watch_unit
(
    input wire logic sys_clk,
    input wire logic arst_n,
    dbg_pins_if.unit pins,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [63:0] reg_wdata,
    output logic [63:0] reg_rdata,
    input wire logic retire,
    input wire logic [63:0] retire_pc,
    input wire dbg_watch_pkg::cpu_mode_e cpu_mode,
    input wire logic fetch_valid,
    input wire logic [63:0] fetch_addr,
    input wire logic load_valid,
    input wire logic store_valid,
    input wire logic [63:0] data_addr,
    input wire logic sw_breakpoint_instr,
    input wire logic debug_return_instr,
    input wire logic [2:0] err_pending_set,
    output logic debug_enter,
    output logic watch_exception,
    output logic redirect,
    output logic [63:0] redirect_pc,
    output logic debug_mode_flag
);
    typedef struct packed {
        logic [63:0] iw_addr;
        logic [31:0] iw_ctrl;
        logic [63:0] dw_addr;
        logic [31:0] dw_ctrl;
        logic [63:0] debug_return_pc;
        logic [63:0] debug_scratch;
        logic [31:0] dbg;
        logic [31:0] ext;
        logic int_seen;
        logic boot_done;
        logic [1:0] boot_cnt;
        logic [63:0] rdata;
        logic enter;
        logic wexc;
        logic redir;
        logic [63:0] rpc;
        logic evt_pin;
    } unit_s;
    unit_s st_ff;
    unit_s nxt_st;

    logic intr_lvl;
    logic boot_lvl;

    pin_sync u_int_sync
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin(pins.debug_interrupt_pin),
        .level(intr_lvl)
    );
    pin_sync u_boot_sync
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin(pins.debug_boot_pin),
        .level(boot_lvl)
    );

    logic in_debug;
    logic ext_on;
    logic iw_hit;
    logic ld_hit;
    logic st_hit;
    logic step_ok;
    logic ss_hit;
    logic int_hit;
    logic [2:0] kinds;
    logic [31:0] dbg_rd;

    always_comb
    begin
        nxt_st = st_ff;
        in_debug = st_ff.dbg[`DBG_MODE_BIT];
        ext_on = st_ff.ext[`EXT_EN_BIT];
        // low address bits 2:0 are masked; watch hits on the 8-byte doubleword
        iw_hit = fetch_valid && st_ff.iw_addr[`IW_ENABLE_BIT]
            && (fetch_addr[63:`WATCH_VADDR_LO]
            == st_ff.iw_addr[63:`WATCH_VADDR_LO]);
        ld_hit = load_valid && st_ff.dw_addr[`DW_LOAD_BIT]
            && (data_addr[63:`WATCH_VADDR_LO]
            == st_ff.dw_addr[63:`WATCH_VADDR_LO]);
        st_hit = store_valid && st_ff.dw_addr[`DW_STORE_BIT]
            && (data_addr[63:`WATCH_VADDR_LO]
            == st_ff.dw_addr[63:`WATCH_VADDR_LO]);
        kinds = {iw_hit, st_hit, ld_hit};
        // non-user stepping needs the privileged bit only in ext mode
        step_ok = (cpu_mode == dbg_watch_pkg::MODE_USER) || !ext_on
            || st_ff.ext[`EXT_PRV_BIT];
        ss_hit = retire && st_ff.dbg[`DBG_SSTEP_BIT] && !in_debug
            && step_ok;
        int_hit = intr_lvl && !st_ff.int_seen && !in_debug;
        nxt_st.int_seen = intr_lvl;
        nxt_st.enter = 1'b0;
        nxt_st.wexc = 1'b0;
        nxt_st.redir = 1'b0;
        nxt_st.rpc = st_ff.rpc;

        // register writes
        if (reg_wr)
        begin
            unique case (reg_sel)
                `SEL_INSTR_WATCH_ADDR:
                    nxt_st.iw_addr = reg_wdata & `IW_ADDR_MASK;
                `SEL_INSTR_WATCH_CTRL:
                    nxt_st.iw_ctrl = reg_wdata[31:0]
                        & `WATCH_CTRL_RW_MASK;
                `SEL_DATA_WATCH_ADDR:
                    nxt_st.dw_addr = reg_wdata & `DW_ADDR_MASK;
                `SEL_DATA_WATCH_CTRL:
                    nxt_st.dw_ctrl = reg_wdata[31:0]
                        & `WATCH_CTRL_RW_MASK;
                `SEL_DEBUG_STATUS:
                begin
                    nxt_st.dbg[`DBG_SSTEP_BIT] = reg_wdata[`DBG_SSTEP_BIT];
                    nxt_st.dbg[`DBG_IEXI_BIT] = reg_wdata[`DBG_IEXI_BIT];
                    // writing one clears a pending bit
                    nxt_st.dbg[`DBG_MCHK_BIT:`DBG_BERR_BIT] =
                        st_ff.dbg[`DBG_MCHK_BIT:`DBG_BERR_BIT]
                        & ~reg_wdata[`DBG_MCHK_BIT:`DBG_BERR_BIT];
                end
                `SEL_EXT_DEBUG:
                begin
                    nxt_st.ext[`EXT_EN_BIT] = reg_wdata[`EXT_EN_BIT];
                    // clear of alt vector only lands with boot low
                    nxt_st.ext[`EXT_ALT_BIT] = reg_wdata[`EXT_ALT_BIT]
                        | boot_lvl;
                    nxt_st.ext[`EXT_PRV_BIT] = reg_wdata[`EXT_PRV_BIT];
                    nxt_st.ext[`EXT_EVENT_BIT] =
                        reg_wdata[`EXT_EVENT_BIT];
                    nxt_st.ext[`EXT_TRIG_HI:`EXT_TRIG_LO] =
                        reg_wdata[`EXT_TRIG_HI:`EXT_TRIG_LO];
                end
                `SEL_RETURN_PC:
                    nxt_st.debug_return_pc = reg_wdata;
                `SEL_SCRATCH:
                    nxt_st.debug_scratch = reg_wdata;
            endcase
        end

        // hardware sets win over software clears
        nxt_st.dbg[`DBG_MCHK_BIT:`DBG_BERR_BIT] =
            nxt_st.dbg[`DBG_MCHK_BIT:`DBG_BERR_BIT] | err_pending_set;
        if (boot_lvl)
            nxt_st.ext[`EXT_ALT_BIT] = 1'b1;
        if (ext_on && |(kinds & st_ff.ext[`EXT_TRIG_HI:`EXT_TRIG_LO]))
            nxt_st.ext[`EXT_EVENT_BIT] = 1'b1;

        // the agent flop and the synchroniser are cleared during reset,
        // so the strap is only trusted once both have filled
        if (!st_ff.boot_done)
        begin
            nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
            if (st_ff.boot_cnt == `BOOT_SETTLE_CNT)
            begin
                nxt_st.boot_done = 1'b1;
                nxt_st.redir = 1'b1;
                nxt_st.rpc = `RESET_VECTOR;
                if (boot_lvl)
                begin
                    nxt_st.dbg[`DBG_MODE_BIT] = 1'b1;
                    nxt_st.ext[`EXT_ALT_BIT] = 1'b1;
                    nxt_st.rpc = `ALT_DEBUG_VECTOR;
                end
            end
        end
        else if (debug_return_instr && in_debug)
        begin
            nxt_st.dbg[`DBG_MODE_BIT] = 1'b0;
            nxt_st.redir = 1'b1;
            nxt_st.rpc = st_ff.debug_return_pc;
        end
        else if (!in_debug && (int_hit || ss_hit || sw_breakpoint_instr
            || (ext_on && |kinds)))
        begin
            nxt_st.dbg[`DBG_MODE_BIT] = 1'b1;
            nxt_st.debug_return_pc = retire_pc;
            nxt_st.dbg[`DBG_INT_STATUS_BIT] = int_hit;
            nxt_st.dbg[`DBG_BP_BIT] = sw_breakpoint_instr;
            nxt_st.dbg[`DBG_SS_BIT] = ss_hit;
            nxt_st.dbg[`DBG_IW_BIT:`DBG_LW_BIT] =
                ext_on ? kinds : 3'h0;
            nxt_st.enter = 1'b1;
            nxt_st.redir = 1'b1;
            nxt_st.rpc = st_ff.ext[`EXT_ALT_BIT] ? `ALT_DEBUG_VECTOR
                : `STD_DEBUG_VECTOR;
        end
        else if (!ext_on && !in_debug && |kinds)
            nxt_st.wexc = 1'b1;

        // read view
        dbg_rd = st_ff.dbg;
        dbg_rd[`DBG_NO_CTRL_REG_BIT] = 1'b1;
        dbg_rd[`DBG_NORMAL_MEM_BIT] = 1'b0;
        dbg_rd[`DBG_IMPR_HI:`DBG_IMPR_LO] = 2'h0;
        dbg_rd[`DBG_VER_HI:`DBG_VER_LO] = `DBG_VERSION;
        if (!ext_on)
            dbg_rd[`DBG_IW_BIT:`DBG_LW_BIT] = 3'h0;
        unique case (reg_sel)
            `SEL_INSTR_WATCH_ADDR: nxt_st.rdata = st_ff.iw_addr;
            `SEL_INSTR_WATCH_CTRL: nxt_st.rdata = {32'h0000_0000,
                st_ff.iw_ctrl | (32'h0000_0001 << `MORE_PAIRS_BIT)};
            `SEL_DATA_WATCH_ADDR: nxt_st.rdata = st_ff.dw_addr;
            `SEL_DATA_WATCH_CTRL:
                nxt_st.rdata = {32'h0000_0000, st_ff.dw_ctrl};
            `SEL_DEBUG_STATUS: nxt_st.rdata = {32'h0000_0000, dbg_rd};
            `SEL_EXT_DEBUG: nxt_st.rdata = {32'h0000_0000, st_ff.ext};
            `SEL_RETURN_PC: nxt_st.rdata = st_ff.debug_return_pc;
            `SEL_SCRATCH: nxt_st.rdata = st_ff.debug_scratch;
        endcase
        nxt_st.evt_pin = nxt_st.ext[`EXT_EVENT_BIT];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pins.debug_event_notify_pin = st_ff.evt_pin;
    assign reg_rdata = st_ff.rdata;
    assign debug_enter = st_ff.enter;
    assign watch_exception = st_ff.wexc;
    assign redirect = st_ff.redir;
    assign redirect_pc = st_ff.rpc;
    assign debug_mode_flag = st_ff.dbg[`DBG_MODE_BIT];
endmodule
`default_nettype wire

// ---- sim/dbg_watch_asserts.sv ----
/*
 concurrent checks on the debug pins and the unit's user side.
 assumes one sys_clk domain; instanced in tb_top beside the pins.
*/
`default_nettype none
`include "dbg_watch_cfg.svh"
module dbg_watch_asserts
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic debug_interrupt_pin,
    input wire logic debug_boot_pin,
    input wire logic debug_event_notify_pin,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [63:0] reg_wdata,
    input wire logic [63:0] reg_rdata,
    input wire logic debug_return_instr,
    input wire logic debug_enter,
    input wire logic redirect,
    input wire logic [63:0] redirect_pc,
    input wire logic debug_mode_flag
);
    logic clr_ff;
    // a falling event pin must trace back to a software clearing write
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            clr_ff <= 1'b0;
        else
            clr_ff <= reg_wr && reg_sel == `SEL_EXT_DEBUG
                && !reg_wdata[`EXT_EVENT_BIT];
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    AST_DEBUG_INTERRUPT_PIN_ENTRY: assert property (
        $rose(debug_interrupt_pin) && !debug_mode_flag
            |-> ##[1:4] debug_enter)
        else $error("no debug entry after interrupt pin");
    AST_ENTER_STATE: assert property (
        debug_enter |-> debug_mode_flag && redirect)
        else $error("debug entry without mode flag or redirect");
    AST_NO_REENTRY: assert property (
        debug_mode_flag && $past(debug_mode_flag) |-> !debug_enter)
        else $error("debug entry while already in debug mode");
    AST_ENTRY_VECTOR: assert property (
        debug_enter |-> redirect_pc == `STD_DEBUG_VECTOR
            || redirect_pc == `ALT_DEBUG_VECTOR)
        else $error("debug entry to a wrong vector");
    AST_RESET_FETCH: assert property (
        $rose(arst_n) |-> ##[0:5] (redirect
            && (redirect_pc == `RESET_VECTOR
            || redirect_pc == `ALT_DEBUG_VECTOR)))
        else $error("no start fetch after reset");
    AST_EVENT_SET: assert property (
        reg_wr && reg_sel == `SEL_EXT_DEBUG && reg_wdata[`EXT_EVENT_BIT]
            |=> debug_event_notify_pin)
        else $error("event pin not set by write");
    AST_EVENT_CLEAR: assert property (
        $fell(debug_event_notify_pin) |-> clr_ff)
        else $error("event pin cleared without software");
    AST_RETURN_EXIT: assert property (
        debug_return_instr && debug_mode_flag |=> redirect && !debug_mode_flag)
        else $error("debug return did not leave debug mode");
    AST_WATCH_TOP: assert property (
        reg_sel inside {`SEL_INSTR_WATCH_CTRL, `SEL_DATA_WATCH_CTRL}
            && $stable(reg_sel) && $past(arst_n)
            |-> reg_rdata[`MORE_PAIRS_BIT]
            == (reg_sel == `SEL_INSTR_WATCH_CTRL))
        else $error("more pairs bit wrong");
    AST_DEBUG_FIXED: assert property (
        reg_sel == `SEL_DEBUG_STATUS && $stable(reg_sel) && $past(arst_n)
            |-> reg_rdata[`DBG_NORMAL_MEM_BIT] == 1'b0
            && reg_rdata[`DBG_IMPR_HI:`DBG_IMPR_LO] == 2'h0
            && reg_rdata[`DBG_VER_HI:`DBG_VER_LO] == `DBG_VERSION)
        else $error("fixed debug bits wrong");
    cover property (debug_enter);
    cover property ($rose(debug_event_notify_pin));
    cover property (redirect && debug_mode_flag);
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 self-checking bench: agent and unit joined by the pins interface.
 assumes rtl header, package and interface are compiled first.
*/
`default_nettype none
`include "dbg_watch_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0;
    logic arst_n = 0;
    logic want_interrupt = 0;
    logic want_boot = 0;
    logic event_seen;
    logic [2:0] reg_sel = 0;
    logic reg_wr = 0;
    logic [63:0] reg_wdata = 0;
    logic [63:0] reg_rdata;
    logic retire = 0;
    logic [63:0] retire_pc = 0;
    dbg_watch_pkg::cpu_mode_e cpu_mode = dbg_watch_pkg::MODE_USER;
    logic fetch_valid = 0;
    logic [63:0] fetch_addr = 0;
    logic load_valid = 0;
    logic store_valid = 0;
    logic [63:0] data_addr = 0;
    logic sw_breakpoint_instr = 0;
    logic debug_return_instr = 0;
    logic [2:0] err_pending_set = 0;
    logic debug_enter;
    logic watch_exception;
    logic redirect;
    logic [63:0] redirect_pc;
    logic debug_mode_flag;
    int error_cnt = 0;
    int comparisons = 0;
    always #50 sys_clk = ~sys_clk;
    dbg_pins_if pins();
    debug_agent u_debug_agent
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .pins(pins),
        .want_interrupt(want_interrupt), .want_boot(want_boot),
        .event_seen(event_seen)
    );
    core_debug_watch_unit u_core_debug_watch_unit
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .pins(pins),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .retire(retire), .retire_pc(retire_pc),
        .cpu_mode(cpu_mode), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .load_valid(load_valid),
        .store_valid(store_valid), .data_addr(data_addr),
        .sw_breakpoint_instr(sw_breakpoint_instr),
        .debug_return_instr(debug_return_instr),
        .err_pending_set(err_pending_set), .debug_enter(debug_enter),
        .watch_exception(watch_exception), .redirect(redirect),
        .redirect_pc(redirect_pc), .debug_mode_flag(debug_mode_flag)
    );
    dbg_watch_asserts u_dbg_watch_asserts
    (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .debug_interrupt_pin(pins.debug_interrupt_pin),
        .debug_boot_pin(pins.debug_boot_pin),
        .debug_event_notify_pin(pins.debug_event_notify_pin),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .debug_return_instr(debug_return_instr),
        .debug_enter(debug_enter), .redirect(redirect),
        .redirect_pc(redirect_pc), .debug_mode_flag(debug_mode_flag)
    );
    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [2:0] s, input logic [63:0] d);
        @(negedge sys_clk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge sys_clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [2:0] s, output logic [63:0] d);
        @(negedge sys_clk);
        reg_sel = s;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // k: 0 return, 1 breakpoint, 2 fetch, 3 retire, 4 load, 5 store
    task automatic pulse(input int k);
        @(negedge sys_clk);
        {store_valid, load_valid, retire, fetch_valid, sw_breakpoint_instr,
            debug_return_instr} = 6'h01 << k;
        @(negedge sys_clk);
        {store_valid, load_valid, retire, fetch_valid, sw_breakpoint_instr,
            debug_return_instr} = 6'h00;
    endtask
    // pulses stand one cycle, so they are polled at every falling edge
    task automatic wait_hi(input bit on_enter);
        for (int i = 0; i < 20; i++)
        begin
            if ((on_enter ? debug_enter : redirect) === 1'b1)
                return;
            @(negedge sys_clk);
        end
        error_cnt++;
        $display("Error handshake exp 1 got 0");
        print_verdict;
    endtask
    task automatic reset_unit(input logic boot, input logic [63:0] vec);
        arst_n = 0;
        want_boot = boot;
        cyc(16);
        arst_n = 1;
        wait_hi(0);
        chk("reset_pc", vec, redirect_pc);
        chk("reset_mode", {63'h0, boot}, {63'h0, debug_mode_flag});
        cyc(4);
        want_boot = 0;
    endtask
    initial
    begin
        logic [63:0] d;
        reset_unit(0, `RESET_VECTOR);
        wr(3'h0, '1);
        rd(3'h0, d);
        chk("iaddr", `IW_ADDR_MASK, d);
        wr(3'h2, '1);
        rd(3'h2, d);
        chk("daddr", `DW_ADDR_MASK, d);
        wr(3'h1, '1);
        rd(3'h1, d);
        chk("ictrl", 64'hc0ff_0ff8, d);
        wr(3'h3, '1);
        rd(3'h3, d);
        chk("dctrl", 64'h40ff_0ff8, d);
        wr(3'h7, 64'h5a5a_1234);
        rd(3'h7, d);
        chk("scratch", 64'h5a5a_1234, d);
        rd(3'h4, d);
        chk("dbg_fixed", 64'h2000_8000, d & 64'h300f_801c);
        @(negedge sys_clk);
        err_pending_set = 3'h7;
        @(negedge sys_clk);
        err_pending_set = 3'h0;
        rd(3'h4, d);
        chk("pending", 64'h7, {61'h0, d[23:21]});
        wr(3'h4, 64'h40_0000);
        rd(3'h4, d);
        chk("pending_w1", 64'h5, {61'h0, d[23:21]});
        wr(3'h5, 64'h20);
        chk("event_pin", 64'h1, {63'h0, pins.debug_event_notify_pin});
        cyc(3);
        chk("event_seen", 64'h1, {63'h0, event_seen});
        wr(3'h5, 64'h0);
        chk("event_clr", 64'h0, {63'h0, pins.debug_event_notify_pin});
        want_interrupt = 1;
        wait_hi(1);
        chk("intr_pc", `STD_DEBUG_VECTOR, redirect_pc);
        cyc(8);
        want_interrupt = 0;
        wr(3'h5, 64'h8000_0010);
        wr(3'h0, 64'h2004);
        wr(3'h6, 64'h4000);
        pulse(0);
        chk("ret_pc", 64'h4000, redirect_pc);
        fetch_addr = 64'h2000;
        pulse(2);
        wait_hi(1);
        chk("watch_exc", 64'h0, {63'h0, watch_exception});
        rd(3'h4, d);
        chk("watch_kind", 64'h4, {61'h0, d[4:2]});
        chk("watch_evt", 64'h1, {63'h0, pins.debug_event_notify_pin});
        pulse(0);
        wr(3'h2, 64'h3003);
        data_addr = 64'h3000;
        pulse(4);
        wait_hi(1);
        rd(3'h4, d);
        chk("load_kind", 64'h1, {61'h0, d[4:2]});
        pulse(0);
        pulse(5);
        wait_hi(1);
        rd(3'h4, d);
        chk("store_kind", 64'h2, {61'h0, d[4:2]});
        pulse(0);
        wr(3'h4, 64'h100);
        cpu_mode = dbg_watch_pkg::MODE_KERNEL;
        pulse(3);
        cyc(4);
        chk("step_kernel", 64'h0, {63'h0, debug_mode_flag});
        cpu_mode = dbg_watch_pkg::MODE_USER;
        pulse(3);
        wait_hi(1);
        wr(3'h4, 64'h0);
        pulse(0);
        pulse(1);
        wait_hi(1);
        pulse(0);
        want_boot = 1;
        cyc(4);
        rd(3'h5, d);
        chk("boot_alt", 64'h1, {63'h0, d[30]});
        chk("boot_mode", 64'h0, {63'h0, debug_mode_flag});
        wr(3'h5, 64'h8000_0000);
        rd(3'h5, d);
        chk("alt_held", 64'h1, {63'h0, d[30]});
        want_boot = 0;
        cyc(4);
        wr(3'h5, 64'h8000_0000);
        rd(3'h5, d);
        chk("alt_clr", 64'h0, {63'h0, d[30]});
        pulse(1);
        wait_hi(1);
        wr(3'h5, 64'h0);
        pulse(0);
        pulse(2);
        chk("watch_exc_on", 64'h1, {63'h0, watch_exception});
        chk("watch_no_mode", 64'h0, {63'h0, debug_mode_flag});
        reset_unit(1, `ALT_DEBUG_VECTOR);
        print_verdict;
    end
endmodule
`default_nettype wire
